// >>> cmd_status_regs.svh
`ifndef CMD_STATUS_REGS_SVH
`define CMD_STATUS_REGS_SVH

// standard event flag positions
`define ESR_PON 7
`define ESR_URQ 6
`define ESR_CME 5
`define ESR_EXE 4
`define ESR_DDE 3
`define ESR_QYE 2
`define ESR_RQC 1
`define ESR_OPC 0
`define ESR_RESET 8'h80

// status byte positions
`define STB_MSS 6
`define STB_ESB 5
`define STB_MAV 4

// message characters
`define CH_LF 8'h0A
`define CH_SPACE 8'h20
`define CH_STAR 8'h2A
`define CH_COLON 8'h3A
`define CH_SEMI 8'h3B
`define CH_QMARK 8'h3F

// header keywords, compared against the last four header characters, DATA against any four in a row, SOUR against the first four
`define KW_CLS "*CLS"
`define KW_RST "*RST"
`define KW_SAV "*SAV"
`define KW_TRG "*TRG"
`define KW_SRE "*SRE"
`define KW_WAI "*WAI"
`define KW_OPC "*OPC"
`define KW_ESRQ "ESR?"
`define KW_IDNQ "IDN?"
`define KW_STBQ "STB?"
`define KW_SOUR "SOUR"
`define KW_DATA "DATA"

`endif

// >>> cmd_pkg.sv
package cmd_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } rx_char_t;

  typedef enum logic {RESP_NUM, RESP_IDN} resp_kind_t;

  typedef struct packed {
    resp_kind_t kind;
    logic [7:0] value;
  } resp_req_t;

  typedef enum {
    CMD_NONE, CMD_CLS, CMD_ESRQ, CMD_IDNQ, CMD_STBQ, CMD_RST,
    CMD_SAV, CMD_NOOP, CMD_DATA, CMD_BAD
  } cmd_t;

endpackage

// >>> response_tx.sv
`timescale 1ns/100ps
`include "cmd_status_regs.svh"
module response_tx import cmd_pkg::*; #(
  parameter int IDN_LEN = 23,
  parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "MAKER,MODEL0,SN0000,HW0"
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request side
  input wire logic req_valid,
  input wire resp_req_t req,
  input wire logic flush,
  output logic busy,
  // byte stream
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_eoi,
  input wire logic tx_ready
);
  // index counter is seven bits wide
  if (IDN_LEN < 1 || IDN_LEN > 100) begin : g_bad_len
    $error("IDN_LEN out of range");
  end

  resp_req_t cur, next_cur;
  logic active, next_active, next_eoi;
  logic [6:0] idx, next_idx;
  logic [7:0] next_byte;

  // numbers go out without leading zeros
  function automatic logic [6:0] skip(input logic [7:0] v);
    skip = (v >= 8'h64) ? 7'h00 : (v >= 8'h0A) ? 7'h01 : 7'h02;
  endfunction

  function automatic logic [6:0] last_of(input resp_req_t r);
    last_of = (r.kind == RESP_IDN) ? 7'(IDN_LEN) : 7'h03 - skip(r.value);
  endfunction

  function automatic logic [7:0] char_at(input resp_req_t r,
                                         input logic [6:0] i);
    logic [6:0] p;
    p = i + skip(r.value);
    if (r.kind == RESP_IDN)
      char_at = (i < 7'(IDN_LEN)) ?
        IDN_TEXT[8*(IDN_LEN-1-int'(i)) +: 8] : `CH_LF;
    else if (p == 7'h00) char_at = 8'h30 + 8'(r.value / 8'h64);
    else if (p == 7'h01) char_at = 8'h30 + 8'((r.value / 8'h0A) % 8'h0A);
    else if (p == 7'h02) char_at = 8'h30 + 8'(r.value % 8'h0A);
    else char_at = `CH_LF;
  endfunction

  always_comb begin
    next_active = active;
    next_cur = cur;
    next_idx = idx;
    next_byte = tx_byte;
    next_eoi = tx_eoi;
    if (flush) begin
      next_active = 1'b0;
    end else if (!active && req_valid) begin
      next_active = 1'b1;
      next_cur = req;
      next_idx = 7'h00;
      next_byte = char_at(req, 7'h00);
      next_eoi = (last_of(req) == 7'h00);
    end else if (active && tx_ready) begin
      if (idx == last_of(cur)) begin
        next_active = 1'b0;
      end else begin
        next_idx = idx + 7'h01;
        next_byte = char_at(cur, idx + 7'h01);
        next_eoi = (idx + 7'h01 == last_of(cur));
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      active <= 1'b0;
      cur <= '0;
      idx <= 7'h00;
      tx_byte <= 8'h00;
      tx_eoi <= 1'b0;
    end else begin
      active <= next_active;
      cur <= next_cur;
      idx <= next_idx;
      tx_byte <= next_byte;
      tx_eoi <= next_eoi;
    end
  end

  assign busy = active;
  assign tx_valid = active;

  a_resp_term: assert property (@(posedge clock) disable iff (reset)
    tx_valid && tx_eoi |-> tx_byte == `CH_LF)
    else $error("response end without line feed");
endmodule // response_tx

// >>> remote_command_status_unit.sv
`timescale 1ns/100ps
`include "cmd_status_regs.svh"
// What this block does
// - clear status empties the event flags, and drops a pending reply only when it is the first message of its line.
// - the event flag query replies with the flags as a number and then zeroes them.
// - the event flags are power on, user request, command, execution, device, query error, request control and done, bit 7 down to 0.
// - the identification query replies with maker, model, serial and hardware version separated by commas.
// - reset brings the decades back to the power-up setting and leaves bus state and status untouched.
// - save pulses a store to flash, and slot 0 also becomes the power-up setting.
// - the status byte query replies with the status byte, bit 6 being the summary.
// - the data command takes one decimal digit per decade and drives each decade with it.
// - trigger and service request style commands are accepted and change nothing.
// - an unknown command changes nothing but raises the command error flag.
// - a message ends on semicolon, line feed or end flag, and every reply ends with line feed plus end flag.
module remote_command_status_unit import cmd_pkg::*; #(
  parameter int NDIG = 12,
  parameter int IDN_LEN = 23,
  // arbitrary neutral identification text
  parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "MAKER,MODEL0,SN0000,HW0"
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // program message characters
  input wire logic RX_VALID,
  input wire rx_char_t RX_CHAR,
  // response message bytes
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  output logic TX_EOI,
  input wire logic TX_READY,
  // status
  output logic [7:0] EVENT_FLAGS,
  output logic [7:0] STATUS_BYTE,
  // decades and flash
  output logic [4*NDIG-1:0] DECADES,
  input wire logic [4*NDIG-1:0] POWERON_DECADES,
  output logic SAVE_STROBE,
  output logic [7:0] SAVE_SLOT
);
  if (NDIG < 1 || NDIG > 32) begin : g_bad_ndig
    $error("NDIG out of range");
  end

  logic [7:0] standard_event_flags, next_esr, esr_set, esr_clr;
  logic [4:0] hdr_len, next_len;
  logic star, next_star, data_hit, next_data, in_param, next_par;
  logic [31:0] win, next_win, first4, next_first4;
  logic [7:0] param_num, next_num, c;
  logic [4*NDIG-1:0] param_dig, next_dig, poweron, next_poweron;
  logic [4*NDIG-1:0] next_dec;
  logic [5:0] param_cnt, next_cnt;
  logic param_bad, next_bad, first_unit, next_first;
  logic loaded, next_save, term_ch, ending, param_ok;
  logic [7:0] next_slot;
  logic req_valid, flush, tx_busy;
  resp_req_t req;
  cmd_t cmd;

  function automatic logic [7:0] to_upper(input logic [7:0] ch);
    to_upper = (ch >= 8'h61 && ch <= 8'h7A) ? ch - 8'h20 : ch;
  endfunction

  function automatic logic is_digit(input logic [7:0] ch);
    is_digit = (ch >= 8'h30 && ch <= 8'h39);
  endfunction

  // summary bits are plain ors: no enable masks exist in this unit
  always_comb begin
    STATUS_BYTE = 8'h00;
    STATUS_BYTE[`STB_ESB] = |standard_event_flags;
    STATUS_BYTE[`STB_MAV] = tx_busy;
    STATUS_BYTE[`STB_MSS] = STATUS_BYTE[`STB_ESB] | tx_busy;
  end

  always_comb begin
    c = to_upper(RX_CHAR.data);
    term_ch = (c == `CH_SEMI) || (c == `CH_LF);
    next_len = hdr_len;
    next_star = star;
    next_win = win;
    next_first4 = first4;
    next_data = data_hit;
    next_par = in_param;
    next_num = param_num;
    next_dig = param_dig;
    next_cnt = param_cnt;
    next_bad = param_bad;
    if (RX_VALID && !term_ch) begin
      if (!in_param) begin
        if (c == `CH_SPACE && hdr_len != 5'h00) begin
          next_par = 1'b1;
        end else if (c > `CH_SPACE &&
                     !(c == `CH_COLON && hdr_len == 5'h00)) begin
          if (hdr_len == 5'h00) next_star = (c == `CH_STAR);
          if (hdr_len < 5'h04) next_first4 = {first4[23:0], c};
          next_win = {win[23:0], c};
          if (hdr_len != 5'h1F) next_len = hdr_len + 5'h01;
          if (next_win == `KW_DATA) next_data = 1'b1;
        end
      end else if (is_digit(c)) begin
        next_dig = {param_dig[4*NDIG-5:0], c[3:0]};
        next_num = 8'(param_num * 8'h0A + {4'h0, c[3:0]});
        if (param_cnt != 6'h3F) next_cnt = param_cnt + 6'h01;
      end else if (c > `CH_SPACE) begin
        next_bad = 1'b1;
      end
    end
    ending = RX_VALID && (term_ch || RX_CHAR.eoi);
    param_ok = !next_bad && next_cnt != 6'h00;
    if (!ending || next_len == 5'h00) cmd = CMD_NONE;
    else if (next_star && next_len == 5'h04 && next_win == `KW_CLS)
      cmd = CMD_CLS;
    else if (next_star && next_len == 5'h04 && next_win == `KW_RST)
      cmd = CMD_RST;
    else if (next_star && next_len == 5'h04 && next_win == `KW_SAV)
      cmd = CMD_SAV;
    else if (next_star && next_len == 5'h04 &&
             (next_win == `KW_TRG || next_win == `KW_SRE ||
              next_win == `KW_WAI || next_win == `KW_OPC))
      cmd = CMD_NOOP;
    else if (next_star && next_len == 5'h05 && next_win == `KW_ESRQ)
      cmd = CMD_ESRQ;
    else if (next_star && next_len == 5'h05 && next_win == `KW_IDNQ)
      cmd = CMD_IDNQ;
    else if (next_star && next_len == 5'h05 && next_win == `KW_STBQ)
      cmd = CMD_STBQ;
    else if (!next_star && next_first4 == `KW_SOUR && next_data &&
             next_win[7:0] != `CH_QMARK)
      cmd = CMD_DATA;
    else cmd = CMD_BAD;
  end

  always_comb begin
    esr_set = 8'h00;
    esr_clr = 8'h00;
    next_dec = loaded ? DECADES : POWERON_DECADES;
    next_poweron = loaded ? poweron : POWERON_DECADES;
    next_save = 1'b0;
    next_slot = SAVE_SLOT;
    req_valid = 1'b0;
    req = '{kind: RESP_NUM, value: standard_event_flags};
    flush = 1'b0;
    case (cmd)
      CMD_CLS: begin
        esr_clr = 8'hFF;
        flush = first_unit;
      end
      CMD_ESRQ, CMD_IDNQ, CMD_STBQ: begin
        // a query while a reply is still pending is refused
        if (tx_busy) begin
          esr_set[`ESR_QYE] = 1'b1;
        end else begin
          req_valid = 1'b1;
          if (cmd == CMD_IDNQ) req.kind = RESP_IDN;
          if (cmd == CMD_STBQ) req.value = STATUS_BYTE;
          if (cmd == CMD_ESRQ) esr_clr = 8'hFF;
        end
      end
      CMD_RST: next_dec = poweron;
      CMD_SAV: begin
        if (param_ok) begin
          next_save = 1'b1;
          next_slot = next_num;
          if (next_num == 8'h00) next_poweron = DECADES;
        end else begin
          esr_set[`ESR_EXE] = 1'b1;
        end
      end
      CMD_DATA: begin
        if (param_ok && next_cnt <= 6'(NDIG)) next_dec = next_dig;
        else esr_set[`ESR_EXE] = 1'b1;
      end
      CMD_BAD: esr_set[`ESR_CME] = 1'b1;
      default: ;
    endcase
    // a flag raised in the clearing cycle survives
    next_esr = (standard_event_flags & ~esr_clr) | esr_set;
    next_first = ending ? !term_ch || c == `CH_LF : first_unit;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      standard_event_flags <= `ESR_RESET;
      hdr_len <= 5'h00;
      star <= 1'b0;
      win <= 32'h0000_0000;
      first4 <= 32'h0000_0000;
      data_hit <= 1'b0;
      in_param <= 1'b0;
      param_num <= 8'h00;
      param_dig <= '0;
      param_cnt <= 6'h00;
      param_bad <= 1'b0;
      first_unit <= 1'b1;
      loaded <= 1'b0;
      DECADES <= '0;
      poweron <= '0;
      SAVE_STROBE <= 1'b0;
      SAVE_SLOT <= 8'h00;
    end else begin
      standard_event_flags <= next_esr;
      first_unit <= next_first;
      loaded <= 1'b1;
      DECADES <= next_dec;
      poweron <= next_poweron;
      SAVE_STROBE <= next_save;
      SAVE_SLOT <= next_slot;
      if (ending) begin
        hdr_len <= 5'h00;
        star <= 1'b0;
        win <= 32'h0000_0000;
        first4 <= 32'h0000_0000;
        data_hit <= 1'b0;
        in_param <= 1'b0;
        param_num <= 8'h00;
        param_dig <= '0;
        param_cnt <= 6'h00;
        param_bad <= 1'b0;
      end else begin
        hdr_len <= next_len;
        star <= next_star;
        win <= next_win;
        first4 <= next_first4;
        data_hit <= next_data;
        in_param <= next_par;
        param_num <= next_num;
        param_dig <= next_dig;
        param_cnt <= next_cnt;
        param_bad <= next_bad;
      end
    end
  end

  response_tx #(.IDN_LEN(IDN_LEN), .IDN_TEXT(IDN_TEXT)) u_tx (
    .clock(CLOCK),
    .reset(SYS_RST),
    .req_valid(req_valid),
    .req(req),
    .flush(flush),
    .busy(tx_busy),
    .tx_valid(TX_VALID),
    .tx_byte(TX_BYTE),
    .tx_eoi(TX_EOI),
    .tx_ready(TX_READY)
  );

  assign EVENT_FLAGS = standard_event_flags;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_save_issued;
    ##1 SAVE_STROBE && SAVE_SLOT == $past(next_num);
  endsequence

  a_cls_clears: assert property (cmd == CMD_CLS |=> EVENT_FLAGS == 8'h00)
    else $error("clear status left flags set");
  a_cls_flush: assert property (cmd == CMD_CLS && first_unit && TX_VALID
    |=> !TX_VALID)
    else $error("pending reply survived clear status");
  a_esr_read: assert property (cmd == CMD_ESRQ && !tx_busy
    |=> TX_VALID && EVENT_FLAGS == 8'h00)
    else $error("event flag query did not reply and clear");
  a_esr_power: assert property ($rose(loaded) |-> EVENT_FLAGS[`ESR_PON])
    else $error("power on flag missing after reset");
  a_rst_restore: assert property (cmd == CMD_RST
    |=> DECADES == $past(poweron) && $stable(EVENT_FLAGS))
    else $error("reset did not restore power up setting");
  a_save_default: assert property (cmd == CMD_SAV && param_ok &&
    next_num == 8'h00 |=> poweron == $past(DECADES))
    else $error("save 0 did not update power up setting");
  a_save_strobe: assert property (cmd == CMD_SAV && param_ok
    |-> s_save_issued)
    else $error("save did not pulse the store");
  a_stb_summary: assert property (STATUS_BYTE[`STB_MSS] ==
    (STATUS_BYTE[`STB_ESB] || STATUS_BYTE[`STB_MAV]))
    else $error("status summary bit wrong");
  a_data_drive: assert property (cmd == CMD_DATA && param_ok &&
    next_cnt <= 6'(NDIG) |=> DECADES == $past(next_dig))
    else $error("decades not driven from data digits");
  a_noop_still: assert property (cmd == CMD_NOOP
    |=> $stable(DECADES) && $stable(EVENT_FLAGS))
    else $error("accepted no-op changed state");
  a_unknown_err: assert property (cmd == CMD_BAD
    |=> EVENT_FLAGS[`ESR_CME] && $stable(DECADES))
    else $error("unknown command not flagged or changed state");
endmodule // remote_command_status_unit

// >>> controller_model.sv
`timescale 1ns/100ps
module controller_model import cmd_pkg::*; #(
  parameter int RST_WAIT = 16
) (
  // clock
  input wire logic clock,
  // program side
  output logic rx_valid,
  output rx_char_t rx_char,
  // response side
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_eoi,
  output logic tx_ready
);
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_char = '0;
    tx_ready = 1'b0;
  end
  // message ends on lf inside s or on the eoi flag
  task automatic send(input string s, input bit use_eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_char.data = s[i];
      rx_char.eoi = use_eoi && (i == s.len() - 1);
    end
    @(negedge clock);
    rx_valid = 1'b0;
    // released data must not look like the last char
    rx_char = ~rx_char;
    if (s.substr(0, 3) == "*RST") repeat (RST_WAIT) @(negedge clock);
  endtask
  // slow mode drops ready on every other cycle
  task automatic read(output string r, output bit ok);
    int n;
    bit done;
    r = "";
    ok = 1'b0;
    done = 1'b0;
    n = 0;
    while (n < 300 && !done) begin
      @(negedge clock);
      tx_ready = !slow || n[0];
      if (tx_valid === 1'b1 && tx_ready) begin
        done = (tx_eoi === 1'b1);
        if (done) ok = (tx_byte === 8'h0A);
        else r = {r, string'(tx_byte)};
      end
      n++;
    end
    @(negedge clock);
    tx_ready = 1'b0;
  endtask
endmodule // controller_model

// >>> tb_remote_command_status_unit.sv
`timescale 1ns/100ps
module tb_remote_command_status_unit import cmd_pkg::*; ();
  localparam logic [47:0] PWR = 48'h0000_0098_7654;
  logic clock;
  logic sys_rst;
  logic rx_valid;
  rx_char_t rx_char;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_eoi;
  logic tx_ready;
  logic [7:0] event_flags;
  logic [7:0] status_byte;
  logic [47:0] decades;
  logic save_strobe;
  logic [7:0] save_slot;
  int fails = 0;
  int cmp_count = 0;
  int saves = 0;
  remote_command_status_unit remote_command_status_unit_i (
    .CLOCK(clock), .SYS_RST(sys_rst), .RX_VALID(rx_valid),
    .RX_CHAR(rx_char), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
    .TX_EOI(tx_eoi), .TX_READY(tx_ready), .EVENT_FLAGS(event_flags),
    .STATUS_BYTE(status_byte), .DECADES(decades),
    .POWERON_DECADES(PWR), .SAVE_STROBE(save_strobe),
    .SAVE_SLOT(save_slot)
  );
  controller_model controller_model_i (
    .clock(clock), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_eoi(tx_eoi),
    .tx_ready(tx_ready)
  );
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // a stuck strobe counts many times
  always @(posedge clock) begin
    if (save_strobe === 1'b1) saves <= saves + 1;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp_v(input string what, input logic [47:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_s(input string what, e, g);
    cmp_count++;
    if (g != e) begin
      fails++;
      $display("ERROR %s expected %s seen %s", what, e, g);
    end
  endtask
  task automatic send(input string s);
    controller_model_i.send(s, 1'b0);
  endtask
  task automatic ask(input string q, input bit eoi, input string e);
    string r;
    bit ok;
    controller_model_i.send(q, eoi);
    controller_model_i.read(r, ok);
    cmp_s(q, e, r);
    cmp_v("reply end", 48'h1, {47'h0, ok});
  endtask
  task automatic t_reset();
    cmp_v("flags in reset", 48'h80, event_flags);
    // summary bit follows the event summary even in reset
    cmp_v("stb in reset", 48'h60, status_byte);
  endtask
  task automatic t_status();
    cmp_v("powerup", PWR, decades);
    ask("*ESR?\n", 1'b0, "128");
    cmp_v("flags read", 48'h0, event_flags);
    send("BOGUS\n");
    cmp_v("bad flags", 48'h20, event_flags);
    cmp_v("bad decades", PWR, decades);
    cmp_v("stb", 48'h60, status_byte);
    ask("*STB?\n", 1'b0, "96");
    controller_model_i.slow = 1'b1;
    ask("*ESR?", 1'b1, "32");
    controller_model_i.slow = 1'b0;
    ask("*idn?\n", 1'b0, "MAKER,MODEL0,SN0000,HW0");
  endtask
  task automatic t_clear();
    string r;
    bit ok;
    send("XYZ\n");
    send("*IDN?\n");
    send("*CLS\n");
    cmp_v("abort", 48'h0, {47'h0, tx_valid});
    cmp_v("cls flags", 48'h0, event_flags);
    send("XYZ\n");
    send("*IDN?;*CLS\n");
    cmp_v("kept", 48'h1, {47'h0, tx_valid});
    cmp_v("cls2 flags", 48'h0, event_flags);
    send("*STB?\n");
    cmp_v("busy query", 48'h4, event_flags);
    controller_model_i.read(r, ok);
    cmp_s("kept reply", "MAKER,MODEL0,SN0000,HW0", r);
    cmp_v("kept end", 48'h1, {47'h0, ok});
    ask("*ESR?\n", 1'b0, "4");
  endtask
  task automatic t_data();
    send("SOUR:DATA 123\n");
    cmp_v("data", 48'h123, decades);
    send("SOURCE:DIGITAL:DATA 1234567890123\n");
    cmp_v("long data", 48'h123, decades);
    cmp_v("long flags", 48'h10, event_flags);
    send("*CLS;*TRG;*WAI;*OPC\n");
    cmp_v("noop decades", 48'h123, decades);
    cmp_v("noop flags", 48'h0, event_flags);
  endtask
  task automatic t_save();
    send("*SAV 3\n");
    // counter sees the pulse one edge after it is launched
    @(negedge clock);
    cmp_v("strobe", 48'h1, 48'(saves));
    cmp_v("slot", 48'h3, save_slot);
    send("*RST\n");
    cmp_v("rst", PWR, decades);
    send("SOUR:DATA 456;*SAV 0\n");
    @(negedge clock);
    cmp_v("strobe0", 48'h2, 48'(saves));
    cmp_v("slot0", 48'h0, save_slot);
    send("SOUR:DATA 9;QQ\n");
    send("*RST\n");
    cmp_v("new powerup", 48'h456, decades);
    cmp_v("rst flags", 48'h20, event_flags);
    send("*SAV\n");
    @(negedge clock);
    cmp_v("bad save", 48'h30, event_flags);
    cmp_v("bad save strobe", 48'h2, 48'(saves));
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    t_reset();
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    t_status();
    t_clear();
    t_data();
    t_save();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    close_out();
  end
endmodule // tb_remote_command_status_unit
